// *** hdl/cfg_latch_pkg.sv ***
package cfg_latch_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int ADDR_W    = 4;   // register address width
    localparam int DATA_W    = 8;   // register data width
    localparam int NUM_BYTES = 4;   // bytes in the latch array
    localparam int NUM_PORTS = 8;   // ports 0..6 and 12
    localparam int PORT_PINS = 8;   // pins in one port
    localparam int DRV_W     = 2;   // width of one drive field
    localparam int LOW_PORTS = 4;   // drive fields in byte 0
    localparam int CNT_W     = 16;  // write counter width

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_DRIVE_LOW   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_DRIVE_HIGH  = 4'h1;
    localparam logic [ADDR_W-1:0] REG_RESET_DEBUG = 4'h2;
    localparam logic [ADDR_W-1:0] REG_BOOT_ECC    = 4'h3;
    localparam logic [ADDR_W-1:0] REG_APPLIED_0   = 4'h4;
    localparam logic [ADDR_W-1:0] REG_APPLIED_1   = 4'h5;
    localparam logic [ADDR_W-1:0] REG_APPLIED_2   = 4'h6;
    localparam logic [ADDR_W-1:0] REG_APPLIED_3   = 4'h7;
    localparam logic [ADDR_W-1:0] REG_WRITES_LO   = 4'h8;
    localparam logic [ADDR_W-1:0] REG_WRITES_HI   = 4'h9;

    // ------------------------------------------------------------
    // factory defaults of the four latch bytes
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] DEF_BYTE0 = 8'h00;
    localparam logic [DATA_W-1:0] DEF_BYTE1 = 8'h00;
    localparam logic [DATA_W-1:0] DEF_BYTE2 = 8'h40;
    localparam logic [DATA_W-1:0] DEF_BYTE3 = 8'h0A;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EXT_RST_BIT  = 7;  // byte 2
    localparam int DBG_ACC_BIT  = 6;  // byte 2
    localparam int BOOT_SPD_BIT = 0;  // byte 3
    localparam int DPS_LSB      = 1;  // byte 3, two bits
    localparam int ECC_BIT      = 3;  // byte 3
    localparam int PHASE_LSB    = 4;  // byte 3, four bits

    // ------------------------------------------------------------
    // encodings and constants
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DRV_ANALOG_HIZ  = 2'b00,
        DRV_DIGITAL_HIZ = 2'b01,
        DRV_PULL_UP     = 2'b10,
        DRV_PULL_DOWN   = 2'b11
    } drive_mode_e;

    typedef enum logic [1:0] {
        DBG_JTAG5 = 2'b00,
        DBG_JTAG4 = 2'b01,
        DBG_SWD   = 2'b10,
        DBG_OFF   = 2'b11
    } dbg_port_e;

    localparam logic [6:0]       BOOT_MHZ_SLOW = 7'h0C;  // 12 MHz
    localparam logic [6:0]       BOOT_MHZ_FAST = 7'h30;  // 48 MHz
    localparam logic [CNT_W-1:0] CNT_MAX       = 16'hFFFF;
    localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;

endpackage

// *** hdl/config_latch_loader.sv ***
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps

// Notes on behaviour
// RULE1: four latch bytes applied whenever reset ends
// RULE2: drive field picks analog, digital, pull-up, pull-down
// RULE3: whole port shares one drive mode
// RULE4: ext reset bit turns shared pin into reset
// RULE5: debug access bit zero blocks all debug
// RULE6: boot speed bit picks 12 or 48 MHz
// RULE7: debug port select: jtag5, jtag4, swd, off
// RULE8: ecc bit one keeps extra flash for ecc
// RULE9: four-bit phase delay passed to clock logic
// RULE10: tools must limit latch erase/write cycles
// RULE11: sampled in reset, frozen until next reset
// RULE12: byte 0 ports 0-3, byte 1 ports 4,5,6,12

module config_latch_loader
    import cfg_latch_pkg::*;
(
    // clock and resets
    input  wire logic                           SYS_CLK,
    input  wire logic                           RST_N,
    input  wire logic                           POR_N,
    // register port
    input  wire logic [ADDR_W-1:0]              REG_ADDR,
    input  wire logic [DATA_W-1:0]              REG_WDATA,
    input  wire logic                           REG_WR,
    input  wire logic                           REG_RD,
    output logic      [DATA_W-1:0]              REG_RDATA,
    // port reset drive
    output logic      [NUM_PORTS*DRV_W-1:0]     PORT_DRIVE_MODE,
    output logic      [NUM_PORTS*PORT_PINS-1:0] PIN_ANALOG_HIZ,
    output logic      [NUM_PORTS*PORT_PINS-1:0] PIN_DIGITAL_HIZ,
    output logic      [NUM_PORTS*PORT_PINS-1:0] PIN_PULL_UP,
    output logic      [NUM_PORTS*PORT_PINS-1:0] PIN_PULL_DOWN,
    // reset pin and debug
    output logic                                EXT_RESET_SEL,
    output logic                                DEBUG_ACCESS_EN,
    output logic      [1:0]                     DEBUG_PORT_MODE,
    output logic                                DEBUG_JTAG5_EN,
    output logic                                DEBUG_JTAG4_EN,
    output logic                                DEBUG_SWD_EN,
    // boot clock, flash, phase
    output logic                                BOOT_CLK_FAST,
    output logic      [6:0]                     BOOT_CLK_MHZ,
    output logic                                ECC_ENABLE,
    output logic                                ECC_AREA_FREE,
    output logic      [3:0]                     PHASE_DELAY
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // true for the four latch byte offsets
    function automatic logic is_latch_addr(input logic [ADDR_W-1:0] a);
        is_latch_addr = (a <= REG_BOOT_ECC);
    endfunction

    // debug port enables {jtag5, jtag4, swd}, gated by access bit
    function automatic logic [2:0] dbg_ports(input logic [1:0] sel,
                                             input logic       acc);
        logic [2:0] r;
        r = 3'h0;
        if (acc) begin
            case (sel)
                DBG_JTAG5: r = 3'b100;
                DBG_JTAG4: r = 3'b010;
                DBG_SWD:   r = 3'b001;
                default:   r = 3'b000;  // all debug ports off
            endcase
        end
        dbg_ports = r;
    endfunction

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] latch_q [NUM_BYTES];  // nonvolatile bytes
    logic [DATA_W-1:0] cfg_q   [NUM_BYTES];  // applied copy
    logic [CNT_W-1:0]  writes_q;             // latch writes seen
    logic [DATA_W-1:0] rdata_q;              // read answer
    logic [2:0]        dbg_q;                // decoded debug ports
    logic [6:0]        mhz_q;                // boot clock rate
    logic [ADDR_W-1:0] rd_idx;               // register offset of read
    logic [1:0]        wr_idx;               // latch index of write

    assign wr_idx = REG_ADDR[1:0];
    assign rd_idx = REG_ADDR;

    // ------------------------------------------------------------
    // latch array
    // ------------------------------------------------------------

    // kept across device reset; only power-on restores defaults.
    // writes are refused while the device is in reset so that
    // the byte being sampled cannot change under the sample.
    always_ff @(posedge SYS_CLK) begin
        if (!POR_N) begin
            latch_q[0] <= DEF_BYTE0;
            latch_q[1] <= DEF_BYTE1;
            latch_q[2] <= DEF_BYTE2;
            latch_q[3] <= DEF_BYTE3;
        end else if (RST_N && REG_WR && is_latch_addr(REG_ADDR)) begin
            latch_q[wr_idx] <= REG_WDATA;
        end
    end

    // ------------------------------------------------------------
    // wear counter
    // ------------------------------------------------------------

    // lets a programming tool see how often the array was written;
    // saturates rather than wrapping so wear is never understated
    always_ff @(posedge SYS_CLK) begin
        if (!POR_N) begin
            writes_q <= '0;
        end else if (RST_N && REG_WR && is_latch_addr(REG_ADDR)) begin
            if (writes_q != CNT_MAX) begin
                writes_q <= writes_q + 1'b1;  // [RULE10]
            end
        end
    end

    // ------------------------------------------------------------
    // applied configuration
    // ------------------------------------------------------------

    // tracks the latch for as long as reset is low, so the value
    // at the release edge is the one that stays in force
    always_ff @(posedge SYS_CLK) begin
        if (!POR_N) begin
            cfg_q[0] <= DEF_BYTE0;
            cfg_q[1] <= DEF_BYTE1;
            cfg_q[2] <= DEF_BYTE2;
            cfg_q[3] <= DEF_BYTE3;
        end else if (!RST_N) begin
            cfg_q[0] <= latch_q[0];  // [RULE1] [RULE11]
            cfg_q[1] <= latch_q[1];  // [RULE1] [RULE11]
            cfg_q[2] <= latch_q[2];  // [RULE1] [RULE11]
            cfg_q[3] <= latch_q[3];  // [RULE1] [RULE11]
        end
    end

    // decoded debug enables, sampled the same way
    always_ff @(posedge SYS_CLK) begin
        if (!POR_N) begin
            dbg_q <= dbg_ports(DEF_BYTE3[DPS_LSB +: 2], DEF_BYTE2[DBG_ACC_BIT]);
        end else if (!RST_N) begin
            dbg_q <= dbg_ports(latch_q[3][DPS_LSB +: 2],
                               latch_q[2][DBG_ACC_BIT]);  // [RULE5] [RULE7]
        end
    end

    // boot clock rate in MHz for the oscillator setup
    always_ff @(posedge SYS_CLK) begin
        if (!POR_N) begin
            mhz_q <= BOOT_MHZ_SLOW;
        end else if (!RST_N) begin
            if (latch_q[3][BOOT_SPD_BIT]) begin
                mhz_q <= BOOT_MHZ_FAST;  // [RULE6]
            end else begin
                mhz_q <= BOOT_MHZ_SLOW;  // [RULE6]
            end
        end
    end

    // ------------------------------------------------------------
    // port drive decoders
    // ------------------------------------------------------------

    // index 0..3 are ports 0..3 in byte 0; index 4..7 are ports
    // 4, 5, 6 and 12 in byte 1, lowest port in the low bits
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            localparam int BYTE = (p < LOW_PORTS) ? 0 : 1;
            localparam int LSB  = (p % LOW_PORTS) * DRV_W;
            port_drive_decode u_drv (
                .clk         (SYS_CLK),
                .rst_n       (RST_N),
                .por_n       (POR_N),
                .field       (latch_q[BYTE][LSB +: DRV_W]),  // [RULE12]
                .mode_q      (PORT_DRIVE_MODE[p*DRV_W +: DRV_W]),
                .analog_q    (PIN_ANALOG_HIZ[p*PORT_PINS +: PORT_PINS]),
                .digital_q   (PIN_DIGITAL_HIZ[p*PORT_PINS +: PORT_PINS]),
                .pull_up_q   (PIN_PULL_UP[p*PORT_PINS +: PORT_PINS]),
                .pull_down_q (PIN_PULL_DOWN[p*PORT_PINS +: PORT_PINS])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------

    // answer stands for exactly one cycle after the strobe;
    // unmapped offsets and reads during reset answer zero
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || !REG_RD) begin
            rdata_q <= ZERO_BYTE;
        end else begin
            case (rd_idx)
                REG_DRIVE_LOW:   rdata_q <= latch_q[0];
                REG_DRIVE_HIGH:  rdata_q <= latch_q[1];
                REG_RESET_DEBUG: rdata_q <= latch_q[2];
                REG_BOOT_ECC:    rdata_q <= latch_q[3];
                REG_APPLIED_0:   rdata_q <= cfg_q[0];
                REG_APPLIED_1:   rdata_q <= cfg_q[1];
                REG_APPLIED_2:   rdata_q <= cfg_q[2];
                REG_APPLIED_3:   rdata_q <= cfg_q[3];
                REG_WRITES_LO:   rdata_q <= writes_q[7:0];
                REG_WRITES_HI:   rdata_q <= writes_q[15:8];
                default:         rdata_q <= ZERO_BYTE;  // unmapped
            endcase
        end
    end

    assign REG_RDATA = rdata_q;

    // ------------------------------------------------------------
    // outputs, all straight from flip-flops except ECC_AREA_FREE, which goes through an inverter
    // ------------------------------------------------------------
    assign EXT_RESET_SEL   = cfg_q[2][EXT_RST_BIT];      // [RULE4]
    assign DEBUG_ACCESS_EN = cfg_q[2][DBG_ACC_BIT];      // [RULE5]
    assign DEBUG_PORT_MODE = cfg_q[3][DPS_LSB +: 2];     // [RULE7]
    assign DEBUG_JTAG5_EN  = dbg_q[2];
    assign DEBUG_JTAG4_EN  = dbg_q[1];
    assign DEBUG_SWD_EN    = dbg_q[0];
    assign BOOT_CLK_FAST   = cfg_q[3][BOOT_SPD_BIT];     // [RULE6]
    assign BOOT_CLK_MHZ    = mhz_q;
    assign ECC_ENABLE      = cfg_q[3][ECC_BIT];          // [RULE8]
    assign ECC_AREA_FREE   = !cfg_q[3][ECC_BIT];         // [RULE8]
    assign PHASE_DELAY     = cfg_q[3][PHASE_LSB +: 4];   // [RULE9]

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    // applied bytes follow the latch one edge later inside reset
    AST_LOAD_IN_RESET: assert property ( // [RULE1]
        @(posedge SYS_CLK) disable iff (!POR_N)
        (!RST_N && $past(POR_N)) |=> (cfg_q[3] == $past(latch_q[3])
                       && cfg_q[0] == $past(latch_q[0]))
        ) else $error("configuration not taken from latch in reset");

    // applied bytes 2 and 3 and the port drive modes do not change while out of reset
    AST_FROZEN: assert property ( // [RULE11]
        @(posedge SYS_CLK) disable iff (!RST_N || !POR_N)
        $past(RST_N) |-> ($stable(cfg_q[2]) && $stable(cfg_q[3])
                          && $stable(PORT_DRIVE_MODE))
        ) else $error("applied configuration changed outside reset");

    // a latch write shows up in the latch read two cycles on
    AST_WRITE_READBACK: assert property ( // [RULE1]
        @(posedge SYS_CLK) disable iff (!RST_N || !POR_N)
        (REG_WR && REG_ADDR == REG_BOOT_ECC) ##1 (REG_RD && REG_ADDR == REG_BOOT_ECC
            && !REG_WR) |=> (REG_RDATA == $past(REG_WDATA, 2))
        ) else $error("latch byte did not read back");

    AST_EXT_RESET: assert property ( // [RULE4]
        @(posedge SYS_CLK) disable iff (!RST_N || !POR_N)
        EXT_RESET_SEL == cfg_q[REG_RESET_DEBUG[1:0]][EXT_RST_BIT]
        ) else $error("external reset select wrong");

    AST_DEBUG_BLOCKED: assert property ( // [RULE5]
        @(posedge SYS_CLK) disable iff (!RST_N || !POR_N)
        !DEBUG_ACCESS_EN |-> !(DEBUG_JTAG5_EN || DEBUG_JTAG4_EN || DEBUG_SWD_EN)
        ) else $error("debug port open while access blocked");

    AST_DEBUG_SELECT: assert property ( // [RULE7]
        @(posedge SYS_CLK) disable iff (!RST_N || !POR_N)
        {DEBUG_JTAG5_EN, DEBUG_JTAG4_EN, DEBUG_SWD_EN}
            == dbg_ports(DEBUG_PORT_MODE, DEBUG_ACCESS_EN)
        ) else $error("debug port enables do not match select");

    AST_BOOT_RATE: assert property ( // [RULE6]
        @(posedge SYS_CLK) disable iff (!RST_N || !POR_N)
        BOOT_CLK_MHZ == (BOOT_CLK_FAST ? BOOT_MHZ_FAST : BOOT_MHZ_SLOW)
        ) else $error("boot clock rate does not match speed bit");

    AST_ECC_USE: assert property ( // [RULE8]
        @(posedge SYS_CLK) disable iff (!RST_N || !POR_N)
        (ECC_ENABLE != ECC_AREA_FREE) && (ECC_ENABLE == cfg_q[3][ECC_BIT])
        ) else $error("ecc area use inconsistent");

    AST_PHASE: assert property ( // [RULE9]
        @(posedge SYS_CLK) disable iff (!RST_N || !POR_N)
        PHASE_DELAY == cfg_q[3][7:4]
        ) else $error("phase delay not taken from byte 3");

    // port 12 drive comes from the top bits of byte 1
    AST_PORT_MAP: assert property ( // [RULE12]
        @(posedge SYS_CLK) disable iff (!RST_N || !POR_N)
        (PORT_DRIVE_MODE[15:14] == cfg_q[1][7:6])
        && (PORT_DRIVE_MODE[1:0] == cfg_q[0][1:0])
        ) else $error("port drive field mapped to wrong port");

endmodule

// *** hdl/port_drive_decode.sv ***
`timescale 1ns/10ps

module port_drive_decode
    import cfg_latch_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 por_n,
    // drive field as stored in the latch
    input  wire logic [DRV_W-1:0]     field,
    // applied mode and per-pin controls
    output logic      [DRV_W-1:0]     mode_q,
    output logic      [PORT_PINS-1:0] analog_q,
    output logic      [PORT_PINS-1:0] digital_q,
    output logic      [PORT_PINS-1:0] pull_up_q,
    output logic      [PORT_PINS-1:0] pull_down_q
);

    // ------------------------------------------------------------
    // sampled mode, frozen outside reset
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!por_n) begin
            mode_q <= DRV_ANALOG_HIZ;
        end else if (!rst_n) begin
            mode_q <= field;  // [RULE11]
        end
    end

    // ------------------------------------------------------------
    // one decoder per pin, all fed by the same field
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < PORT_PINS; i++) begin : g_pin
            // every pin takes the port's mode, no per-pin choice
            always_ff @(posedge clk) begin
                if (!por_n) begin
                    analog_q[i]    <= 1'b1;
                    digital_q[i]   <= 1'b0;
                    pull_up_q[i]   <= 1'b0;
                    pull_down_q[i] <= 1'b0;
                end else if (!rst_n) begin
                    analog_q[i]    <= (field == DRV_ANALOG_HIZ);   // [RULE2] [RULE3]
                    digital_q[i]   <= (field == DRV_DIGITAL_HIZ);  // [RULE2] [RULE3]
                    pull_up_q[i]   <= (field == DRV_PULL_UP);      // [RULE2] [RULE3]
                    pull_down_q[i] <= (field == DRV_PULL_DOWN);    // [RULE2] [RULE3]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_PINS_ALIKE: assert property ( // [RULE3]
        @(posedge clk) disable iff (!rst_n)
        (pull_up_q == '0 || pull_up_q == '1) && (analog_q == '0 || analog_q == '1))
        else $error("pins of one port differ in drive mode");

    AST_MODE_DECODE: assert property ( // [RULE2]
        @(posedge clk) disable iff (!rst_n)
        (pull_down_q[0] == (mode_q == DRV_PULL_DOWN))
        && (digital_q[0] == (mode_q == DRV_DIGITAL_HIZ)))
        else $error("pin control does not match drive mode");

endmodule

// *** verification/nonvolatile_boot_config_latches_tb.sv ***
`timescale 1ns/10ps

module nonvolatile_boot_config_latches_tb
    import cfg_latch_pkg::*;
();

    // ------------------------------------------------------------
    // stimulus and observed ports
    // ------------------------------------------------------------
    logic                           SYS_CLK   = 1'b0;
    logic                           RST_N     = 1'b0;
    logic                           POR_N     = 1'b0;
    logic [ADDR_W-1:0]              REG_ADDR  = 4'h0;
    logic [DATA_W-1:0]              REG_WDATA = 8'h00;
    logic                           REG_WR    = 1'b0;
    logic                           REG_RD    = 1'b0;
    logic [DATA_W-1:0]              REG_RDATA;
    logic [NUM_PORTS*DRV_W-1:0]     PORT_DRIVE_MODE;
    logic [NUM_PORTS*PORT_PINS-1:0] PIN_ANALOG_HIZ;
    logic [NUM_PORTS*PORT_PINS-1:0] PIN_DIGITAL_HIZ;
    logic [NUM_PORTS*PORT_PINS-1:0] PIN_PULL_UP;
    logic [NUM_PORTS*PORT_PINS-1:0] PIN_PULL_DOWN;
    logic                           EXT_RESET_SEL;
    logic                           DEBUG_ACCESS_EN;
    logic [1:0]                     DEBUG_PORT_MODE;
    logic                           DEBUG_JTAG5_EN;
    logic                           DEBUG_JTAG4_EN;
    logic                           DEBUG_SWD_EN;
    logic                           BOOT_CLK_FAST;
    logic [6:0]                     BOOT_CLK_MHZ;
    logic                           ECC_ENABLE;
    logic                           ECC_AREA_FREE;
    logic [3:0]                     PHASE_DELAY;
    int                             bad_count   = 0;  // mismatches seen
    int                             checks_done = 0;  // comparisons made
    logic [31:0]                    img;              // latch image as last applied

    // 200 MHz clock
    always #2.5 SYS_CLK = ~SYS_CLK;

    config_latch_loader config_latch_loader_i (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .POR_N(POR_N),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .PORT_DRIVE_MODE(PORT_DRIVE_MODE), .PIN_ANALOG_HIZ(PIN_ANALOG_HIZ),
        .PIN_DIGITAL_HIZ(PIN_DIGITAL_HIZ), .PIN_PULL_UP(PIN_PULL_UP),
        .PIN_PULL_DOWN(PIN_PULL_DOWN), .EXT_RESET_SEL(EXT_RESET_SEL),
        .DEBUG_ACCESS_EN(DEBUG_ACCESS_EN), .DEBUG_PORT_MODE(DEBUG_PORT_MODE),
        .DEBUG_JTAG5_EN(DEBUG_JTAG5_EN), .DEBUG_JTAG4_EN(DEBUG_JTAG4_EN),
        .DEBUG_SWD_EN(DEBUG_SWD_EN), .BOOT_CLK_FAST(BOOT_CLK_FAST),
        .BOOT_CLK_MHZ(BOOT_CLK_MHZ), .ECC_ENABLE(ECC_ENABLE),
        .ECC_AREA_FREE(ECC_AREA_FREE), .PHASE_DELAY(PHASE_DELAY)
    );

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one-cycle write strobe
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge SYS_CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD   <= 1'b0;
        #1;
        d = REG_RDATA;
    endtask

    // power-on: factory bytes back, then device reset released one edge later
    task automatic power_on();
        @(posedge SYS_CLK);
        POR_N <= 1'b0;
        RST_N <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        POR_N <= 1'b1;
        @(posedge SYS_CLK);
        RST_N <= 1'b1;
        @(posedge SYS_CLK);
        #1;
        img = {DEF_BYTE3, DEF_BYTE2, DEF_BYTE1, DEF_BYTE0};
    endtask

    // device reset pulse: latch bytes get sampled while low
    task automatic dev_reset();
        @(posedge SYS_CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        @(posedge SYS_CLK);
        #1;
    endtask

    // every decoded output against the image, worked out field by field
    task automatic chk_cfg(input logic [31:0] im);
        logic [1:0] m;
        logic [1:0] dps;
        dps = im[26:25];
        for (int p = 0; p < NUM_PORTS; p++) begin
            m = im[p*2 +: 2];
            chk(PORT_DRIVE_MODE[p*2 +: 2], m);
            chk(PIN_ANALOG_HIZ[p*8 +: 8], {8{m == 2'b00}});
            chk(PIN_DIGITAL_HIZ[p*8 +: 8], {8{m == 2'b01}});
            chk(PIN_PULL_UP[p*8 +: 8], {8{m == 2'b10}});
            chk(PIN_PULL_DOWN[p*8 +: 8], {8{m == 2'b11}});
        end
        chk(EXT_RESET_SEL, im[23]);
        chk(DEBUG_ACCESS_EN, im[22]);
        chk(DEBUG_PORT_MODE, dps);
        chk({DEBUG_JTAG5_EN, DEBUG_JTAG4_EN, DEBUG_SWD_EN},
            {3{im[22]}} & {dps == 2'b00, dps == 2'b01, dps == 2'b10});
        chk({BOOT_CLK_FAST, BOOT_CLK_MHZ}, im[24] ? 8'hB0 : 8'h0C);
        chk({ECC_ENABLE, ECC_AREA_FREE}, {im[27], ~im[27]});
        chk(PHASE_DELAY, im[31:28]);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // factory values straight after power-on, and stored bytes read back
    task automatic t_defaults();
        logic [7:0] d;
        power_on();
        chk({PORT_DRIVE_MODE, EXT_RESET_SEL, DEBUG_ACCESS_EN}, 18'h0_0001);
        chk({DEBUG_PORT_MODE, BOOT_CLK_MHZ, ECC_ENABLE}, 10'b01_0001100_1);
        chk_cfg(img);
        for (int a = 0; a < NUM_BYTES; a++) begin
            reg_rd(4'(a), d);
            chk(d, img[a*8 +: 8]);
        end
    endtask

    // every drive mode on every port; outputs frozen until the reset pulse
    task automatic t_drive();
        for (int r = 0; r < 4; r++) begin
            reg_wr(REG_DRIVE_LOW, {2'(r+3), 2'(r+2), 2'(r+1), 2'(r)});
            reg_wr(REG_DRIVE_HIGH, {2'(r), 2'(r+1), 2'(r+2), 2'(r+3)});
            #1;
            chk_cfg(img);
            img[15:0] = {2'(r), 2'(r+1), 2'(r+2), 2'(r+3),
                         2'(r+3), 2'(r+2), 2'(r+1), 2'(r)};
            dev_reset();
            chk_cfg(img);
        end
    endtask

    // all debug ports with access on and off, both speeds, ecc and phase
    task automatic t_misc();
        for (int k = 0; k < 8; k++) begin
            img[23:16] = {k[0], k[2], 6'h00};
            img[31:24] = {4'(k*2+1), ~k[0], k[1:0], k[1]};
            reg_wr(REG_RESET_DEBUG, img[23:16]);
            reg_wr(REG_BOOT_ECC, img[31:24]);
            dev_reset();
            chk_cfg(img);
        end
    endtask

    // back-to-back write/read, read data for one cycle, refused accesses
    task automatic t_regs();
        logic [7:0] c;
        logic [7:0] d;
        reg_rd(REG_WRITES_LO, c);
        @(posedge SYS_CLK);
        REG_ADDR  <= REG_RESET_DEBUG;
        REG_WDATA <= 8'h24;
        REG_WR    <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR    <= 1'b0;
        REG_RD    <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD    <= 1'b0;
        #1;
        chk(REG_RDATA, 8'h24);
        @(posedge SYS_CLK);
        #1;
        chk(REG_RDATA, 8'h00);
        chk(EXT_RESET_SEL, img[23]);
        reg_rd(REG_WRITES_LO, d);
        chk(d, c + 8'h01);
        reg_rd(4'hA, d);
        chk(d, 8'h00);
        reg_wr(REG_APPLIED_0, 8'h5A);
        reg_rd(REG_APPLIED_0, d);
        chk(d, img[7:0]);
        // a write while held in reset is dropped
        @(posedge SYS_CLK);
        RST_N <= 1'b0;
        reg_wr(REG_BOOT_ECC, ~img[31:24]);
        @(posedge SYS_CLK);
        RST_N <= 1'b1;
        img[23:16] = 8'h24;
        reg_rd(REG_BOOT_ECC, d);
        chk(d, img[31:24]);
        chk_cfg(img);
    endtask

    // ------------------------------------------------------------
    // main sequence: second power-on at the end restores factory bytes
    // ------------------------------------------------------------
    initial begin
        t_defaults();
        t_drive();
        t_misc();
        t_regs();
        t_defaults();
        summarize();
    end

endmodule
